// ---- verilog/isvc_consts.svh ----
`ifndef ISVC_CONSTS_SVH
`define ISVC_CONSTS_SVH
`define ISVC_CLK_NS         50
`define ISVC_CLK_PERIOD_NS  20
`define ISVC_ADDR_SKEW_NS   200
`define ISVC_ADDR_SKEW_CYC  ((`ISVC_ADDR_SKEW_NS + `ISVC_CLK_PERIOD_NS - 1) / `ISVC_CLK_PERIOD_NS)
`define ISVC_STB_CYC        2
`define ISVC_TIMEOUT_CYC    1000
`define ISVC_ADDR_W         4
`define ISVC_CC_W           3
`define ISVC_DATA_W         18
`define ISVC_LINE_IDLE      1'b1
`endif

// ---- verilog/isvc_pkg.sv ----
`default_nettype none
package isvc_pkg;
  typedef enum logic [2:0] {A_IDLE, A_SKEW, A_WAIT_SEL, A_STB_ON, A_STB_OFF, A_DROP_TAG, A_DROP_ADDR} adp_state_t;
  typedef enum logic [1:0] {D_IDLE, D_SEL, D_HOLD} dev_state_t;
endpackage
`default_nettype wire

// ---- verilog/isvc_if.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "isvc_consts.svh"
interface isvc_if;
  logic [`ISVC_ADDR_W-1:0] addr_n;
  logic                    svc_n;
  logic                    stb_n;
  logic                    sel_n;
  logic [`ISVC_CC_W-1:0]   cc_n;
  logic [`ISVC_DATA_W-1:0] din_n;
  logic                    irq_n;
  modport adapter (output addr_n, svc_n, stb_n, input sel_n, cc_n, din_n, irq_n);
  modport device  (input addr_n, svc_n, stb_n, output sel_n, cc_n, din_n, irq_n);
endinterface
`default_nettype wire

// ---- verilog/isvc_adapter.sv ----
// Summary of operation
// [R1] Address stable before service tag rises
// [R2] At least 200 ns address to tag
// [R3] Device answers only on address and tag
// [R4] Device holds select until tag drops
// [R5] Status and data valid until strobe
// [R6] One strobe pulse after select response
// [R7] Device clears request on strobe lead
// [R8] Drop tag after strobe, keep address
// [R9] Device releases lines when tag drops
// [R10] Withdraw address last
// [R11] All lines active low
// [R12] Three-bit condition code, fixed per sequence
// [R13] Eighteen data lines with odd byte parity
// [R14] Request held until strobe or reset
// [R15] Steps triggered by partner response
// [R16] Timeout on missing select raises error
`timescale 1ns/1ps
`default_nettype none
`include "isvc_consts.svh"
module isvc_adapter
  import isvc_pkg::*;
#(
  parameter int TIMEOUT_CYC = `ISVC_TIMEOUT_CYC
)(
  input  wire logic                    mclk_i,     // Clock
  input  wire logic                    resetn_i,   // Sync reset, active low
  input  wire logic                    ce_i,       // Clock enable
  input  wire logic                    start_i,    // Begin service sequence
  input  wire logic [`ISVC_ADDR_W-1:0] addr_i,     // Device to service
  output logic                         busy_o,     // Sequence running
  output logic                         done_o,     // Sequence ended, pulse
  output logic                         err_o,      // Timeout abort, pulse
  output logic [`ISVC_CC_W-1:0]        cc_o,       // Captured condition code
  output logic [`ISVC_DATA_W-1:0]      data_o,     // Captured inbound data
  output logic                         irq_pend_o, // Request line asserted
  isvc_if.adapter                      bus         // Link
);
  localparam int SKEW = `ISVC_ADDR_SKEW_CYC;
  adp_state_t st_ff, nxt_st;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [`ISVC_ADDR_W-1:0] addr_ff, nxt_addr;
  logic [`ISVC_CC_W-1:0] cc_ff, nxt_cc;
  logic [`ISVC_DATA_W-1:0] data_ff, nxt_data;
  logic done_ff, nxt_done;
  logic err_ff, nxt_err;
  logic irq_ff, nxt_irq;
  logic take_addr, take_resp, end_ok, end_err;
  logic sel;

  // Interface lines are active low
  function automatic logic is_low(input logic line_n);
    is_low = (line_n == 1'b0);  // see [R11]
  endfunction

  assign sel = is_low(bus.sel_n);  // see [R11]

  // Sequencer: select and tag-drop steps wait on the partner's answer; skew and strobe steps are timed
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    take_addr = 1'b0;
    take_resp = 1'b0;
    end_ok    = 1'b0;
    end_err   = 1'b0;
    unique case (st_ff)
      A_IDLE:
      begin
        if (start_i)
        begin
          take_addr = 1'b1;  // see [R1]
          nxt_cnt  = 16'h0000;
          nxt_st   = A_SKEW;
        end
      end
      A_SKEW:
      begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff >= 16'(SKEW - 1))  // see [R2]
        begin
          nxt_cnt = 16'h0000;
          nxt_st  = A_WAIT_SEL;
        end
      end
      A_WAIT_SEL:
      begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (sel)  // see [R15]
        begin
          take_resp = 1'b1;  // see [R5]
          nxt_cnt   = 16'h0000;
          nxt_st    = A_STB_ON;
        end
        else if (cnt_ff >= 16'(TIMEOUT_CYC - 1))  // see [R16]
        begin
          end_err = 1'b1;
          nxt_cnt = 16'h0000;
          nxt_st  = A_DROP_TAG;
        end
      end
      A_STB_ON:
      begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff >= 16'(`ISVC_STB_CYC - 1))  // see [R6]
        begin
          nxt_cnt = 16'h0000;
          nxt_st  = A_STB_OFF;
        end
      end
      A_STB_OFF:
      begin
        nxt_st = A_DROP_TAG;  // see [R8]
      end
      A_DROP_TAG:
      begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (!sel || cnt_ff >= 16'(TIMEOUT_CYC - 1))  // see [R15]
          nxt_st = A_DROP_ADDR;
      end
      A_DROP_ADDR:
      begin
        end_ok = 1'b1;  // see [R10]
        nxt_st = A_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      st_ff  <= A_IDLE;
      cnt_ff <= 16'h0000;
    end
    else if (ce_i)
    begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // Capture of address and device answer
  always_comb
  begin
    nxt_addr = addr_ff;
    nxt_cc   = cc_ff;
    nxt_data = data_ff;
    if (take_addr)
      nxt_addr = addr_i;  // see [R1]
    if (take_resp)
    begin
      nxt_cc   = ~bus.cc_n;  // see [R12]
      nxt_data = ~bus.din_n;  // see [R13]
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      addr_ff <= 4'h0;
      cc_ff   <= 3'h0;
      data_ff <= 18'h00000;
    end
    else if (ce_i)
    begin
      addr_ff <= nxt_addr;
      cc_ff   <= nxt_cc;
      data_ff <= nxt_data;
    end
  end

  // Status pulses and sampled request line
  always_comb
  begin
    nxt_done = end_ok;  // see [R10]
    nxt_err  = end_err;  // see [R16]
    nxt_irq  = is_low(bus.irq_n);  // see [R14]
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      done_ff <= 1'b0;
      err_ff  <= 1'b0;
      irq_ff  <= 1'b0;
    end
    else if (ce_i)
    begin
      done_ff <= nxt_done;
      err_ff  <= nxt_err;
      irq_ff  <= nxt_irq;
    end
  end

  logic addr_on;
  logic svc_on;
  logic stb_on;
  assign addr_on = (st_ff != A_IDLE) && (st_ff != A_DROP_ADDR);  // see [R10]
  assign svc_on  = (st_ff == A_WAIT_SEL) || (st_ff == A_STB_ON) || (st_ff == A_STB_OFF);  // see [R8]
  assign stb_on  = (st_ff == A_STB_ON);  // see [R6]
  // Released address lines idle high
  assign bus.addr_n = addr_on ? ~addr_ff : {`ISVC_ADDR_W{`ISVC_LINE_IDLE}};  // see [R11]
  assign bus.svc_n  = ~svc_on;
  assign bus.stb_n  = ~stb_on;
  assign busy_o     = (st_ff != A_IDLE);
  assign done_o     = done_ff;
  assign err_o      = err_ff;
  assign cc_o       = cc_ff;
  assign data_o     = data_ff;
  assign irq_pend_o = irq_ff;
endmodule // isvc_adapter
`default_nettype wire

// ---- verilog/isvc_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "isvc_consts.svh"
module isvc_device
  import isvc_pkg::*;
#(
  parameter logic [`ISVC_ADDR_W-1:0] MY_ADDR = 4'h0  // Arbitrary default
)(
  input  wire logic                    mclk_i,   // Clock
  input  wire logic                    resetn_i, // Sync reset, active low
  input  wire logic                    ce_i,     // Clock enable
  input  wire logic                    event_i,  // Raise interrupt, pulse
  input  wire logic                    clear_i,  // Halt or reset clears request
  input  wire logic                    par_en_i, // Drive parity lines
  input  wire logic [`ISVC_CC_W-1:0]   cc_i,     // Status to report
  input  wire logic [15:0]             data_i,   // Data to report
  output logic                         pend_o,   // Request outstanding
  output logic                         served_o, // Strobe taken, pulse
  isvc_if.device                       bus       // Link
);
  dev_state_t st_ff, nxt_st;
  logic req_ff, nxt_req, stb_d_ff, nxt_stb_d, srv_ff, nxt_srv;
  logic [`ISVC_CC_W-1:0] cc_ff, nxt_cc;
  logic [`ISVC_DATA_W-1:0] dat_ff, nxt_dat;
  logic hit, svc, stb, stb_rise;

  function automatic logic [`ISVC_DATA_W-1:0] with_par(input logic [15:0] d, input logic en);
    with_par = {en & ~(^d[15:8]), en & ~(^d[7:0]), d};  // see [R13]
  endfunction

  assign hit      = (~bus.addr_n == MY_ADDR);  // see [R11]
  assign svc      = ~bus.svc_n;
  assign stb      = ~bus.stb_n;
  assign stb_rise = stb & ~stb_d_ff;

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_req   = req_ff;
    nxt_cc    = cc_ff;
    nxt_dat   = dat_ff;
    nxt_stb_d = stb;
    nxt_srv   = 1'b0;
    if (event_i)
      nxt_req = 1'b1;
    unique case (st_ff)
      D_IDLE:
      begin
        if (hit && svc && req_ff)  // see [R3]
        begin
          nxt_cc  = cc_i;  // see [R12]
          nxt_dat = with_par(data_i, par_en_i);
          nxt_st  = D_SEL;
        end
      end
      D_SEL:
      begin
        if (stb_rise)
        begin
          nxt_req = event_i;  // see [R7]
          nxt_srv = 1'b1;
        end
        if (!svc)  // see [R4] [R15]
          nxt_st = D_HOLD;
      end
      D_HOLD:
      begin
        nxt_cc  = 3'h0;  // see [R9]
        nxt_dat = 18'h00000;
        nxt_st  = D_IDLE;
      end
    endcase
    if (clear_i)  // see [R14]
      nxt_req = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      st_ff    <= D_IDLE;
      req_ff   <= 1'b0;
      cc_ff    <= 3'h0;
      dat_ff   <= 18'h00000;
      stb_d_ff <= 1'b0;
      srv_ff   <= 1'b0;
    end
    else if (ce_i)
    begin
      st_ff    <= nxt_st;
      req_ff   <= nxt_req;
      cc_ff    <= nxt_cc;
      dat_ff   <= nxt_dat;
      stb_d_ff <= nxt_stb_d;
      srv_ff   <= nxt_srv;
    end
  end

  logic on;
  assign on         = (st_ff == D_SEL);  // see [R5]
  assign bus.sel_n  = ~on;
  assign bus.cc_n   = on ? ~cc_ff : {`ISVC_CC_W{`ISVC_LINE_IDLE}};
  assign bus.din_n  = on ? ~dat_ff : {`ISVC_DATA_W{`ISVC_LINE_IDLE}};
  assign bus.irq_n  = ~req_ff;
  assign pend_o     = req_ff;
  assign served_o   = srv_ff;
endmodule // isvc_device
`default_nettype wire

// ---- tb/isvc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "isvc_consts.svh"
module isvc_chk (
  input wire logic                    mclk_i,   // Clock
  input wire logic                    resetn_i, // Sync reset
  input wire logic [`ISVC_ADDR_W-1:0] addr_n,   // Address
  input wire logic                    svc_n,    // Service tag
  input wire logic                    stb_n,    // Strobe
  input wire logic                    sel_n,    // Select response
  input wire logic [`ISVC_CC_W-1:0]   cc_n,     // Status
  input wire logic [`ISVC_DATA_W-1:0] din_n,    // Inbound data
  input wire logic                    irq_n     // Request
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_addr_skew:
    assert property ($fell(svc_n) |-> addr_n == $past(addr_n, 10)) else $error("tag without skew");
  a_sel_cause:
    assert property ($fell(sel_n) |-> !svc_n) else $error("select without tag");
  a_sel_hold:
    assert property ($rose(sel_n) |-> svc_n) else $error("select dropped early");
  a_data_steady:
    assert property (!sel_n && !$past(sel_n) |-> $stable(cc_n) && $stable(din_n)) else $error("status moved");
  a_strobe_pulse:
    assert property ($fell(stb_n) |-> !sel_n ##1 !stb_n ##1 stb_n) else $error("bad strobe");
  a_strobe_clears:
    assert property ($fell(stb_n) |-> ##[1:3] irq_n) else $error("request kept");
  a_tag_drop:
    assert property ($rose(svc_n) |-> stb_n && $past(stb_n)) else $error("tag dropped in strobe");
  a_addr_last:
    assert property ($changed(addr_n) |-> svc_n && $past(svc_n)) else $error("address moved");
  a_dev_release:
    assert property ($rose(svc_n) |-> ##[1:3] (sel_n && &cc_n && &din_n)) else $error("lines held");
  c_strobe: cover property ($fell(stb_n));
  c_timeout: cover property ($rose(svc_n) && sel_n);
  c_request: cover property ($fell(irq_n));
endmodule // isvc_chk
`default_nettype wire

// ---- tb/tb_interrupt_service_handshake.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "isvc_consts.svh"
module tb_interrupt_service_handshake;
  logic        mclk_i   = 1'b0;
  logic        resetn_i = 1'b0;
  logic        ce_i     = 1'b1;
  logic        start_i  = 1'b0;
  logic [3:0]  addr_i   = 4'h5;
  logic        event_i  = 1'b0;
  logic        clear_i  = 1'b0;
  logic        par_en_i = 1'b1;
  logic [2:0]  cc_i     = 3'h0;
  logic [15:0] data_i   = 16'h0000;
  logic        busy_o, done_o, err_o, irq_pend_o, pend_o, served_o;
  logic [2:0]  cc_o;
  logic [17:0] data_o;
  logic [20:0] expq[$];
  int          error_cnt  = 0;
  int          n_compared = 0;
  int          n_served   = 0;
  isvc_if lnk();
  isvc_adapter #(.TIMEOUT_CYC(20)) u_isvc_adapter (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .start_i(start_i), .addr_i(addr_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o), .cc_o(cc_o),
    .data_o(data_o), .irq_pend_o(irq_pend_o), .bus(lnk.adapter));
  isvc_device #(.MY_ADDR(4'h5)) u_isvc_device (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .event_i(event_i), .clear_i(clear_i), .par_en_i(par_en_i), .cc_i(cc_i), .data_i(data_i),
    .pend_o(pend_o), .served_o(served_o), .bus(lnk.device));
  isvc_chk u_isvc_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_n(lnk.addr_n), .svc_n(lnk.svc_n),
    .stb_n(lnk.stb_n), .sel_n(lnk.sel_n), .cc_n(lnk.cc_n), .din_n(lnk.din_n), .irq_n(lnk.irq_n));
  always #10 mclk_i = ~mclk_i;
  // Strobe acknowledges, counted away from the launching edge
  always @(negedge mclk_i)
    if (served_o === 1'b1)
      n_served++;
  task automatic give_verdict;
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic serve(input logic [3:0] a, input logic want_err);
    int k;
    addr_i = a;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
    chk(busy_o, 1'b1);
    k = 0;
    while (done_o !== 1'b1 && err_o !== 1'b1 && k < 200)
    begin
      tick(1);
      k++;
    end
    if (done_o !== 1'b1 && err_o !== 1'b1)
      error_cnt++;
    chk(err_o, want_err);
    chk(busy_o, want_err);
    if (!want_err)
    begin
      chk({cc_o, data_o}, expq.pop_front());
      chk(lnk.addr_n, 4'hf);
    end
  endtask
  initial
  begin
    void'($urandom(32'h56efa622));
    tick(2);
    resetn_i = 1'b1;
    chk(lnk.svc_n & lnk.sel_n, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      cc_i = 3'($urandom);
      data_i = 16'($urandom);
      par_en_i = 1'($urandom);
      expq.push_back({cc_i, par_en_i & ~^data_i[15:8], par_en_i & ~^data_i[7:0], data_i});
      event_i = 1'b1;
      tick(1);
      event_i = 1'b0;
      tick(1);
      chk(irq_pend_o, 1'b1);
      serve(4'h5, 1'b0);
      chk({pend_o, irq_pend_o}, 2'h0);
      chk(21'(n_served), 21'(i + 1));
    end
    event_i = 1'b1;
    tick(1);
    event_i = 1'b0;
    serve(4'h3, 1'b1);
    chk(pend_o, 1'b1);
    clear_i = 1'b1;
    tick(2);
    clear_i = 1'b0;
    chk(pend_o, 1'b0);
    ce_i = 1'b0;
    event_i = 1'b1;
    start_i = 1'b1;
    tick(2);
    chk({busy_o, pend_o}, 2'h0);
    event_i = 1'b0;
    start_i = 1'b0;
    ce_i = 1'b1;
    event_i = 1'b1;
    tick(1);
    event_i = 1'b0;
    chk(pend_o, 1'b1);
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    chk({busy_o, pend_o, irq_pend_o}, 3'h0);
    serve(4'h5, 1'b1);
    chk(21'(n_served), 21'h000006);
    give_verdict();
  end
endmodule // tb_interrupt_service_handshake
`default_nettype wire
